// ===== pkg/temp_offset_regs.vh
// Register map, field layout and reset constants of the temperature offset correction block
// Functional notes
// - Local sign clear: add local offset
// - Local sign set: subtract local offset
// - Local magnitude in bits 3:0, 0..15
// - Remote sign clear: add remote offset
// - Remote sign set: subtract remote offset
// - Remote magnitude in bits 3:0, 0..15
// - Bits 6:4 writable, read back zero
// - Local offset register resets to zero
// - Remote offset register resets to zero
`ifndef TEMP_OFFSET_REGS_VH
`define TEMP_OFFSET_REGS_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define LOCAL_CORR_IDX 6'h0d
`define REMOTE_CORR_IDX 6'h0e
`define LOCAL_CORR_ADDR ({`LOCAL_CORR_IDX, 2'b00})
`define REMOTE_CORR_ADDR ({`REMOTE_CORR_IDX, 2'b00})
`define CLIP_STATUS_ADDR 8'h40
`define LOCAL_READING_ADDR 8'h44
`define REMOTE_READING_ADDR 8'h48

// ****************************************
// Fields and reset values
// ****************************************
`define CORR_SIGN_BIT 7
`define CORR_RSVD_HI 6
`define CORR_RSVD_LO 4
`define CORR_MAG_HI 3
`define CORR_MAG_LO 0
`define CORR_RESET 8'h00
`define READING_RESET 8'h00
`define CLIP_LOCAL_BIT 0
`define CLIP_REMOTE_BIT 1
`define CLIP_RESET 2'h0
`define TEMP_MAX 10'h07f
`define TEMP_MIN 10'h380
`define READING_MAX 8'h7f
`define READING_MIN 8'h80
`define FLAG_RESET 1'b0
`define CORR_RSVD_ZERO 3'h0
`define GUARD_ZERO 6'h00

`endif

// ===== verilog/temp_offset_correction.v
// Offset correction of local and remote temperature readings with an APB register port
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "temp_offset_regs.vh"

// ****************************************
// Offset register of one channel
// ****************************************
module corr_register (
    // Clock, reset and clock enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Write port
    input wire wr_en,
    input wire [7:0] wr_data,
    // Stored value and bus view
    output reg [7:0] value,
    output wire [7:0] read_view
);

    // Reserved bits are stored as written but hidden from reads
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= `CORR_RESET;
        end else if (ce) begin
            if (wr_en) begin
                value <= wr_data;
            end
        end
    end

    // ****************************************
    // Bus view
    // ****************************************
    assign read_view = {value[`CORR_SIGN_BIT], `CORR_RSVD_ZERO, value[`CORR_MAG_HI:`CORR_MAG_LO]};

endmodule

// ****************************************
// Correction arithmetic of one channel
// ****************************************
module offset_apply (
    // Raw sample and correction setting
    input wire [7:0] raw,
    input wire [7:0] corr,
    // Corrected value and clip indication
    output reg [7:0] result,
    output reg clipped
);

    reg [9:0] ext;
    reg [9:0] mag;
    reg [9:0] sum;

    // Two guard bits keep the true sum visible before saturation,
    // so a large offset never wraps a hot reading into a cold one
    always @* begin
        ext = {raw[7], raw[7], raw};
        mag = {`GUARD_ZERO, corr[`CORR_MAG_HI:`CORR_MAG_LO]};
        if (corr[`CORR_SIGN_BIT]) begin
            sum = ext - mag;
        end else begin
            sum = ext + mag;
        end
        if (!sum[9] && (sum > `TEMP_MAX)) begin
            result = `READING_MAX;
            clipped = 1'b1;
        end else if (sum[9] && (sum < `TEMP_MIN)) begin
            result = `READING_MIN;
            clipped = 1'b1;
        end else begin
            result = sum[7:0];
            clipped = 1'b0;
        end
    end

endmodule

// ****************************************
// Stored reading of one channel
// ****************************************
module reading_stage (
    // Clock, reset and clock enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Corrected sample
    input wire sample_valid,
    input wire [7:0] corrected,
    // Reported reading
    output reg [7:0] reading,
    output reg reading_valid
);

    // Only corrected values are ever stored, so all later users agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reading <= `READING_RESET;
            reading_valid <= 1'b0;
        end else if (ce) begin
            reading_valid <= sample_valid;
            if (sample_valid) begin
                reading <= corrected;
            end
        end
    end

endmodule

// ****************************************
// Sticky flag, write one to clear
// ****************************************
module sticky_flag (
    // Clock, reset and clock enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Events
    input wire set,
    input wire clear,
    // State
    output reg flag
);

    reg next_flag;

    // A new event in the clearing cycle survives the clear
    always @* begin
        next_flag = set | (flag & ~clear);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= `FLAG_RESET;
        end else if (ce) begin
            flag <= next_flag;
        end
    end

endmodule

module temp_offset_correction (
    // Clock, reset and clock enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Raw conversion results
    input wire [7:0] raw_local,
    input wire raw_local_valid,
    input wire [7:0] raw_remote,
    input wire raw_remote_valid,
    // Corrected readings
    output wire [7:0] local_reading,
    output wire local_reading_valid,
    output wire [7:0] remote_reading,
    output wire remote_reading_valid
);

    // ****************************************
    // Signals
    // ****************************************
    wire [7:0] local_corr;
    wire [7:0] remote_corr;
    wire [7:0] local_view;
    wire [7:0] remote_view;
    wire [7:0] local_result;
    wire [7:0] remote_result;
    wire local_over;
    wire remote_over;
    wire local_clip;
    wire remote_clip;
    wire [1:0] clip_status;
    wire [1:0] clip_clear;
    reg [31:0] next_prdata;
    reg next_pslverr;
    wire setup_phase;
    wire access_wr;
    wire lane0_wr;
    wire hit_local;
    wire hit_remote;
    wire hit_clip;
    wire local_wr;
    wire remote_wr;
    wire clip_wr;

    // ****************************************
    // Bus decode
    // ****************************************
    // Bus stalls while the clock enable is low, since no state may move
    assign pready = ce;
    assign setup_phase = psel && !penable;
    assign access_wr = psel && penable && pwrite && ce;
    assign lane0_wr = access_wr && pstrb[0];
    assign hit_local = (paddr == `LOCAL_CORR_ADDR);
    assign hit_remote = (paddr == `REMOTE_CORR_ADDR);
    assign hit_clip = (paddr == `CLIP_STATUS_ADDR);
    assign local_wr = lane0_wr && hit_local;
    assign remote_wr = lane0_wr && hit_remote;
    assign clip_wr = lane0_wr && hit_clip;
    assign clip_clear = clip_wr ? pwdata[1:0] : `CLIP_RESET;

    // ****************************************
    // Offset registers
    // ****************************************
    corr_register corr_register_local (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_en(local_wr),
        .wr_data(pwdata[7:0]),
        .value(local_corr),
        .read_view(local_view)
    );

    corr_register corr_register_remote (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_en(remote_wr),
        .wr_data(pwdata[7:0]),
        .value(remote_corr),
        .read_view(remote_view)
    );

    // ****************************************
    // Correction
    // ****************************************
    offset_apply offset_apply_local (
        .raw(raw_local),
        .corr(local_corr),
        .result(local_result),
        .clipped(local_over)
    );

    offset_apply offset_apply_remote (
        .raw(raw_remote),
        .corr(remote_corr),
        .result(remote_result),
        .clipped(remote_over)
    );

    // ****************************************
    // Clip status, write one to clear
    // ****************************************
    sticky_flag sticky_flag_local (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set(raw_local_valid && local_over),
        .clear(clip_clear[`CLIP_LOCAL_BIT]),
        .flag(local_clip)
    );

    sticky_flag sticky_flag_remote (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set(raw_remote_valid && remote_over),
        .clear(clip_clear[`CLIP_REMOTE_BIT]),
        .flag(remote_clip)
    );

    assign clip_status = {remote_clip, local_clip};

    // ****************************************
    // Corrected readings
    // ****************************************
    reading_stage reading_stage_local (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sample_valid(raw_local_valid),
        .corrected(local_result),
        .reading(local_reading),
        .reading_valid(local_reading_valid)
    );

    reading_stage reading_stage_remote (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sample_valid(raw_remote_valid),
        .corrected(remote_result),
        .reading(remote_reading),
        .reading_valid(remote_reading_valid)
    );

    // ****************************************
    // Read path
    // ****************************************
    // Read data is captured at the end of the setup cycle
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `LOCAL_CORR_ADDR: begin
                next_prdata[7:0] = local_view;
            end
            `REMOTE_CORR_ADDR: begin
                next_prdata[7:0] = remote_view;
            end
            `CLIP_STATUS_ADDR: begin
                next_prdata[1:0] = clip_status;
            end
            `LOCAL_READING_ADDR: begin
                next_prdata[7:0] = pwrite ? 8'h00 : local_reading;
                next_pslverr = pwrite;
            end
            `REMOTE_READING_ADDR: begin
                next_prdata[7:0] = pwrite ? 8'h00 : remote_reading;
                next_pslverr = pwrite;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (setup_phase) begin
                prdata <= pwrite ? 32'h00000000 : next_prdata;
                pslverr <= next_pslverr;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule

// ===== verification/temp_offset_correction_assertions.sv
// Port-level assertions of the offset correction block
`timescale 1ns/1ps
`include "temp_offset_regs.vh"
// ****************
// Checker
// ****************
module temp_offset_checker (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    // Conversion
    input wire [7:0] raw_local,
    input wire raw_local_valid,
    input wire [7:0] raw_remote,
    input wire raw_remote_valid,
    input wire [7:0] local_reading,
    input wire local_reading_valid,
    input wire [7:0] remote_reading,
    input wire remote_reading_valid
);
    // Shadow offsets; arithmetic checks skip raw values that could clip
    reg [7:0] loc;
    reg [7:0] rem;
    wire wr = psel && penable && pwrite && ce && pstrb[0];
    wire [7:0] l_add = raw_local + {4'h0, loc[3:0]};
    wire [7:0] l_sub = raw_local - {4'h0, loc[3:0]};
    wire [7:0] r_add = raw_remote + {4'h0, rem[3:0]};
    wire [7:0] r_sub = raw_remote - {4'h0, rem[3:0]};
    wire rd = psel && penable && !pwrite && ce;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc <= 8'h00;
            rem <= 8'h00;
        end else if (wr && paddr == `LOCAL_CORR_ADDR) begin
            loc <= pwdata[7:0];
        end else if (wr && paddr == `REMOTE_CORR_ADDR) begin
            rem <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_local_add: assert property (raw_local_valid && ce && !loc[7] && raw_local[7:6] == 2'b00
        |=> local_reading == $past(l_add)) else $error("local add wrong");
    a_local_sub: assert property (raw_local_valid && ce && loc[7] && raw_local[7:6] == 2'b00
        |=> local_reading == $past(l_sub)) else $error("local subtract wrong");
    a_remote_add: assert property (raw_remote_valid && ce && !rem[7] && raw_remote[7:6] == 2'b00
        |=> remote_reading == $past(r_add)) else $error("remote add wrong");
    a_remote_sub: assert property (raw_remote_valid && ce && rem[7] && raw_remote[7:6] == 2'b00
        |=> remote_reading == $past(r_sub)) else $error("remote subtract wrong");
    a_local_readback: assert property (rd && paddr == `LOCAL_CORR_ADDR
        |-> prdata == {24'h0, loc[7], 3'h0, loc[3:0]}) else $error("local offset readback wrong");
    a_remote_readback: assert property (rd && paddr == `REMOTE_CORR_ADDR
        |-> prdata == {24'h0, rem[7], 3'h0, rem[3:0]}) else $error("remote offset readback wrong");
    a_local_valid_lat: assert property (ce |=> local_reading_valid == $past(raw_local_valid))
        else $error("local valid timing wrong");
    a_remote_valid_lat: assert property (ce |=> remote_reading_valid == $past(raw_remote_valid))
        else $error("remote valid timing wrong");
    a_local_freeze: assert property (!ce |=> $stable(local_reading) && $stable(local_reading_valid))
        else $error("local reading moved while frozen");
endmodule
bind temp_offset_correction temp_offset_checker temp_offset_checker_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .raw_local(raw_local), .raw_local_valid(raw_local_valid), .raw_remote(raw_remote),
    .raw_remote_valid(raw_remote_valid), .local_reading(local_reading), .local_reading_valid(local_reading_valid),
    .remote_reading(remote_reading), .remote_reading_valid(remote_reading_valid));

// ===== verification/temp_offset_correction_tb_top.sv
// Self-checking bench of the offset correction block
`timescale 1ns/1ps
`include "temp_offset_regs.vh"
module temp_offset_correction_tb_top;
    // ****************
    // Signals
    // ****************
    reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00, raw_local = 8'h00, raw_remote = 8'h00;
    reg raw_local_valid = 1'b0, raw_remote_valid = 1'b0, er;
    reg [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, local_reading_valid, remote_reading_valid;
    wire [7:0] local_reading, remote_reading;
    integer err_count = 0, n_tests = 0;
    temp_offset_correction temp_offset_correction_i (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .raw_local(raw_local), .raw_local_valid(raw_local_valid),
        .raw_remote(raw_remote), .raw_remote_valid(raw_remote_valid), .local_reading(local_reading),
        .local_reading_valid(local_reading_valid), .remote_reading(remote_reading),
        .remote_reading_valid(remote_reading_valid));
    // ****************
    // Tasks
    // ****************
    task chk(input reg [31:0] s, input reg [31:0] x);
        n_tests = n_tests + 1;
        if (s !== x) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Leading edge keeps release and next setup in separate time steps
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task conv(input reg rmt, input reg [7:0] off, input reg [7:0] raw, input reg [7:0] x);
        apb(1'b1, rmt ? `REMOTE_CORR_ADDR : `LOCAL_CORR_ADDR, {24'h0, off});
        raw_local <= raw;
        raw_remote <= raw;
        raw_local_valid <= !rmt;
        raw_remote_valid <= rmt;
        @(posedge pclk);
        raw_local_valid <= 1'b0;
        raw_remote_valid <= 1'b0;
        #1;
        chk(rmt ? remote_reading : local_reading, x);
        chk(rmt ? remote_reading_valid : local_reading_valid, 1'b1);
    endtask
    task t_regs;
        apb(1'b0, `LOCAL_CORR_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `REMOTE_CORR_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `LOCAL_CORR_ADDR, 32'hff);
        apb(1'b0, `LOCAL_CORR_ADDR, 32'h0);
        chk(rd, 32'h8f);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1);
    endtask
    task t_conv;
        conv(1'b0, 8'h0f, 8'h19, 8'h28);
        conv(1'b0, 8'h85, 8'h19, 8'h14);
        conv(1'b1, 8'h0a, 8'h00, 8'h0a);
        conv(1'b1, 8'h8f, 8'h05, 8'hf6);
        conv(1'b1, 8'h70, 8'h22, 8'h22);
    endtask
    task t_clip;
        conv(1'b0, 8'h0f, 8'h7a, 8'h7f);
        apb(1'b0, `CLIP_STATUS_ADDR, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `LOCAL_READING_ADDR, 32'h0);
        chk(rd, 32'h7f);
        apb(1'b1, `CLIP_STATUS_ADDR, 32'h1);
        apb(1'b0, `CLIP_STATUS_ADDR, 32'h0);
        chk(rd, 32'h0);
        conv(1'b1, 8'h8f, 8'h85, 8'h80);
        apb(1'b0, `CLIP_STATUS_ADDR, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, `REMOTE_READING_ADDR, 32'h0);
        chk(rd, 32'h80);
        apb(1'b1, `REMOTE_CORR_ADDR, 32'hff);
        apb(1'b0, `REMOTE_CORR_ADDR, 32'h0);
        chk(rd, 32'h8f);
    endtask
    task t_freeze;
        @(posedge pclk);
        ce <= 1'b0;
        raw_local <= 8'h01;
        raw_local_valid <= 1'b1;
        @(posedge pclk);
        #1;
        chk(pready, 1'b0);
        chk(local_reading_valid, 1'b0);
        chk(local_reading, 8'h7f);
        @(posedge pclk);
        ce <= 1'b1;
        raw_local_valid <= 1'b0;
        @(posedge pclk);
        #1;
        chk(pready, 1'b1);
        chk(local_reading, 8'h7f);
    endtask
    initial begin
        forever #25 pclk = ~pclk;
    end
    initial begin
        #100000;
        err_count = err_count + 1;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_conv;
        t_clip;
        t_freeze;
        finish_test;
    end
endmodule
